// *** pkg/msc_params.svh ***
// Constants of the modem serial control port: addresses, bit positions,
// reset values and timing figures.
// Assumes it is included by its bare name from the type package.
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// ****************************************************************
// Register addresses carried in the address byte
// ****************************************************************
`define MSC_ADDR_RESET   8'h01
`define MSC_ADDR_SETUP   8'hE0
`define MSC_ADDR_TXTONES 8'hE1
`define MSC_ADDR_TXDATA  8'hE3
`define MSC_ADDR_FSKMODE 8'hE7
`define MSC_ADDR_RXDATA  8'hEA
`define MSC_ADDR_IRQMASK 8'hEE
`define MSC_ADDR_FLAGS   8'hEF

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define MSC_SETUP_RELAY_BIT 5
`define MSC_FLAG_RING_CHG_BIT 5
`define MSC_FLAG_ENERGY_BIT 4
`define MSC_FLAG_RING_BIT 6
`define MSC_FLAG_PARITY_BIT 7
`define MSC_FLAG_LATCH_MASK 8'h2F
`define MSC_REG_RESET_VAL 8'h00

// ****************************************************************
// Serial framing counts (bit edges within a transaction)
// ****************************************************************
`define MSC_ADDR_LAST_EDGE 5'h07
`define MSC_DATA_FIRST_EDGE 5'h08
`define MSC_DATA_LAST_EDGE 5'h0F
`define MSC_FRAME_END 5'h10

// ****************************************************************
// Timing reference
// ****************************************************************
`define MSC_REF_CLK_HZ 3579545
`define MSC_CORE_CLK_HZ 20000000

`endif

// *** pkg/msc_pkg.sv ***
// Types of the modem serial control port.
// Assumes the constants header sits beside it on the include path.
`include "msc_params.svh"

package msc_pkg;

  // Phase of the serial link within one transaction
  typedef enum logic [3:0] {
    MSC_PH_ADDR   = 4'b0001,
    MSC_PH_WDATA  = 4'b0010,
    MSC_PH_RDATA  = 4'b0100,
    MSC_PH_IGNORE = 4'b1000
  } msc_phase_t;

  // Link state, cleared by the select at every frame boundary
  typedef struct packed {
    msc_phase_t phase;
    logic [4:0] cnt;
    logic [6:0] sr;
    logic [7:0] rbyte;
  } msc_link_t;

  // Event handed from the link to the core, survives the frame end
  typedef struct packed {
    logic tog;
    logic [7:0] addr;
    logic [7:0] data;
  } msc_evt_t;

  // Core state on the system clock
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic ring_s1;
    logic ring_s2;
    logic ring_prev;
    logic tg_s1;
    logic tg_s2;
    logic tg_prev;
    logic [7:0] setup;
    logic [7:0] txtones;
    logic [7:0] txdata;
    logic [7:0] fskmode;
    logic [7:0] irqmask;
    logic [7:0] flags;
    logic [7:0] sh_flags;
    logic [7:0] sh_rx;
    logic txd_stb;
    logic rxrd_stb;
    logic irq_oe;
    logic relay_oe;
  } msc_core_t;

endpackage

// *** logic/msc_top.sv ***
// Serial control port of a telephone-line modem, device side.
// Assumes the host frames each transaction with an active-low select,
// drives the serial clock only inside frames and holds it low at frame
// edges, and that the modem datapath shares clock_in.
`timescale 1ns/10ps

module msc_top (
  // System clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Serial link from the host
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic cmd_data_in,
  output logic reply_data_out,
  output logic reply_data_oe_out,
  // Open-drain pins
  output logic irq_n_out,
  output logic irq_n_oe_out,
  output logic hook_relay_pulldown_out,
  output logic hook_relay_pulldown_oe_out,
  // Ring detector pin and modem datapath status
  input wire logic ring_detect_in,
  input wire logic tx_ready_in,
  input wire logic tx_underflow_in,
  input wire logic rx_ready_in,
  input wire logic rx_overflow_in,
  input wire logic rx_energy_in,
  input wire logic rx_bad_parity_in,
  input wire logic [7:0] rx_data_in,
  // Control registers toward the modem datapath
  output logic [7:0] setup_out,
  output logic [7:0] tx_tones_out,
  output logic [7:0] fsk_mode_out,
  output logic [7:0] tx_data_out,
  output logic tx_data_strobe_out,
  output logic rx_data_taken_out
);
  import msc_pkg::*;

  msc_link_t lq, ld;
  msc_evt_t eq, ed;
  msc_core_t cq, cd;
  logic rep_q, rep_oe_q;

  // ****************************************************************
  // Link domain, clocked by the host's serial clock
  // ****************************************************************

  // Decode of one completed byte and framing of the transaction
  always_comb begin
    logic [7:0] byte_v;
    byte_v = {lq.sr, cmd_data_in};
    ld = lq;
    ed = eq;
    ld.sr = {lq.sr[5:0], cmd_data_in}; // MSB first
    if (lq.cnt != `MSC_FRAME_END) begin
      ld.cnt = 5'(lq.cnt + 5'h01);
    end
    case (lq.phase)
      MSC_PH_ADDR: begin
        if (lq.cnt == `MSC_ADDR_LAST_EDGE) begin
          ed.addr = byte_v;
          ld.phase = MSC_PH_IGNORE; // Unknown addresses are dropped
          case (byte_v)
            `MSC_ADDR_SETUP, `MSC_ADDR_TXTONES, `MSC_ADDR_TXDATA,
            `MSC_ADDR_FSKMODE, `MSC_ADDR_IRQMASK: begin
              ld.phase = MSC_PH_WDATA;
            end
            `MSC_ADDR_FLAGS: begin
              ld.phase = MSC_PH_RDATA;
              ld.rbyte = cq.sh_flags;
              ed.tog = ~eq.tog;
            end
            `MSC_ADDR_RXDATA: begin
              ld.phase = MSC_PH_RDATA;
              ld.rbyte = cq.sh_rx;
              ed.tog = ~eq.tog;
            end
            `MSC_ADDR_RESET: begin
              ed.tog = ~eq.tog; // Single-byte command, no data follows
            end
            default: begin
            end
          endcase
        end
      end
      MSC_PH_WDATA: begin
        if (lq.cnt == `MSC_DATA_LAST_EDGE) begin
          ed.data = byte_v;
          ed.tog = ~eq.tog;
          ld.phase = MSC_PH_IGNORE; // Extra bits beyond one byte ignored
        end
      end
      default: begin
      end
    endcase
  end

  // Frame state cleared by the select, since the serial clock stops between frames
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lq <= '{phase: MSC_PH_ADDR, cnt: 5'h00, sr: 7'h00, rbyte: 8'h00};
    end else begin
      lq <= ld;
    end
  end

  // Event word outlives the frame so the core can sample it after the toggle
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      eq <= '0;
    end else begin
      eq <= ed;
    end
  end

  // Reply bits change on the falling edge so they stand across the high phase
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      rep_q <= 1'b0;
      rep_oe_q <= 1'b0; // Released as soon as the frame ends
    end else begin
      rep_oe_q <= (lq.phase == MSC_PH_RDATA) && (lq.cnt >= `MSC_DATA_FIRST_EDGE) &&
                  (lq.cnt <= `MSC_DATA_LAST_EDGE);
      rep_q <= lq.rbyte[3'(`MSC_DATA_LAST_EDGE - lq.cnt)];
    end
  end

  // ****************************************************************
  // Core domain, clocked by the reference-derived system clock
  // ****************************************************************

  // Register file, flags and interrupt; events from the link arrive by toggle
  always_comb begin
    logic [7:0] clr_v;
    logic [7:0] set_v;
    logic [7:0] lat_v;
    clr_v = 8'h00;
    set_v = 8'h00;
    lat_v = 8'h00;
    cd = cq;
    cd.cs_s1 = cs_n_in;
    cd.cs_s2 = cq.cs_s1;
    cd.ring_s1 = ring_detect_in;
    cd.ring_s2 = cq.ring_s1;
    cd.ring_prev = cq.ring_s2;
    cd.tg_s1 = eq.tog;
    cd.tg_s2 = cq.tg_s1;
    cd.tg_prev = cq.tg_s2;
    cd.txd_stb = 1'b0;
    cd.rxrd_stb = 1'b0;
    set_v = {2'b00, cq.ring_s2 ^ cq.ring_prev, 1'b0,
             rx_overflow_in, rx_ready_in, tx_underflow_in, tx_ready_in};
    if (cq.tg_s2 != cq.tg_prev) begin
      case (eq.addr)
        `MSC_ADDR_RESET: begin
          cd.setup = `MSC_REG_RESET_VAL;
          cd.txtones = `MSC_REG_RESET_VAL;
          cd.txdata = `MSC_REG_RESET_VAL;
          cd.fskmode = `MSC_REG_RESET_VAL;
          cd.irqmask = `MSC_REG_RESET_VAL;
          clr_v = `MSC_FLAG_LATCH_MASK;
        end
        `MSC_ADDR_SETUP: cd.setup = eq.data;
        `MSC_ADDR_TXTONES: cd.txtones = eq.data;
        `MSC_ADDR_FSKMODE: cd.fskmode = eq.data;
        `MSC_ADDR_IRQMASK: cd.irqmask = eq.data;
        `MSC_ADDR_TXDATA: begin
          cd.txdata = eq.data;
          cd.txd_stb = 1'b1;
        end
        `MSC_ADDR_FLAGS: begin
          // Only clear what the host actually saw, so nothing is lost
          clr_v = cq.sh_flags & `MSC_FLAG_LATCH_MASK;
        end
        `MSC_ADDR_RXDATA: cd.rxrd_stb = 1'b1;
        default: begin
        end
      endcase
    end
    // New events win over a clear in the same cycle
    lat_v = ((cq.flags & ~clr_v) | set_v) & `MSC_FLAG_LATCH_MASK;
    cd.flags = lat_v;
    cd.flags[`MSC_FLAG_ENERGY_BIT] = rx_energy_in;
    cd.flags[`MSC_FLAG_RING_BIT] = cq.ring_s2;
    cd.flags[`MSC_FLAG_PARITY_BIT] = rx_bad_parity_in;
    // Reply shadows move only while no frame is open, so the link reads them static
    if (cq.cs_s2) begin
      cd.sh_flags = cq.flags;
      cd.sh_rx = rx_data_in;
    end
    cd.irq_oe = |(cq.flags & cq.irqmask & `MSC_FLAG_LATCH_MASK);
    cd.relay_oe = cq.setup[`MSC_SETUP_RELAY_BIT];
    // Event word is cleared by the same reset, so an all-zero toggle pipe sees no false event
    if (rst_in) begin
      cd = '0;
    end
  end

  // All core timing runs on one clock taken from the reference
  always_ff @(posedge clock_in) begin
    cq <= cd;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Open-drain pins only ever drive low; the level bit is fixed
  assign reply_data_out = rep_q;
  assign reply_data_oe_out = rep_oe_q;
  assign irq_n_out = 1'b0;
  assign irq_n_oe_out = cq.irq_oe;
  assign hook_relay_pulldown_out = 1'b0;
  assign hook_relay_pulldown_oe_out = cq.relay_oe;
  assign setup_out = cq.setup;
  assign tx_tones_out = cq.txtones;
  assign fsk_mode_out = cq.fskmode;
  assign tx_data_out = cq.txdata;
  assign tx_data_strobe_out = cq.txd_stb;
  assign rx_data_taken_out = cq.rxrd_stb;

endmodule // msc_top

// *** dv/msc_top_properties.sv ***
// Checker of the serial control port, watching the top ports only.
// Assumes it is bound onto msc_top and samples on the system clock.
`timescale 1ns/10ps
module msc_top_properties (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic cs_n_in,
  input wire logic reply_data_oe_out,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_out,
  input wire logic hook_relay_pulldown_out,
  input wire logic hook_relay_pulldown_oe_out,
  input wire logic [7:0] setup_out,
  input wire logic tx_data_strobe_out,
  input wire logic rx_data_taken_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // *******************************
  // Cycles since the select rose
  // *******************************
  logic [3:0] gap_q;
  logic [3:0] gap_d;
  // Saturates so a long idle never wraps into a false write window
  always_comb gap_d = !cs_n_in ? 4'h0 : (gap_q == 4'hF ? gap_q : gap_q + 4'h1);
  always_ff @(posedge clock_in) gap_q <= rst_in ? 4'hF : gap_d;
  sequence s_frame_done; $rose(cs_n_in) ##1 cs_n_in; endsequence
  sequence s_one_pulse(x); x ##1 !x; endsequence
  property p_rpl_done; s_frame_done |-> !reply_data_oe_out; endproperty
  a_rpl_done: assert property (p_rpl_done) else $error("reply driven outside frame");
  property p_rpl_start; $rose(reply_data_oe_out) |-> !cs_n_in; endproperty
  a_rpl_start: assert property (p_rpl_start) else $error("reply on without select");
  property p_irq_lvl; irq_n_out == 1'b0; endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("interrupt pin driven high");
  property p_rly_lvl; hook_relay_pulldown_out == 1'b0; endproperty
  a_rly_lvl: assert property (p_rly_lvl) else $error("relay pin driven high");
  property p_rst_idle;
    $fell(rst_in) |-> !irq_n_oe_out && !hook_relay_pulldown_oe_out && (setup_out == 8'h00);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
  property p_rly_follow; hook_relay_pulldown_oe_out == $past(setup_out[5]); endproperty
  a_rly_follow: assert property (p_rly_follow) else $error("relay enable mismatch");
  property p_strb; tx_data_strobe_out |-> s_one_pulse(tx_data_strobe_out); endproperty
  a_strb: assert property (p_strb) else $error("transmit strobe too long");
  property p_take; rx_data_taken_out |-> s_one_pulse(rx_data_taken_out); endproperty
  a_take: assert property (p_take) else $error("receive taken too long");
  property p_setup_win; !$stable(setup_out) |-> gap_q < 4'hA; endproperty
  a_setup_win: assert property (p_setup_win) else $error("setup changed off frame");
  property p_strb_win; tx_data_strobe_out |-> gap_q < 4'hA; endproperty
  a_strb_win: assert property (p_strb_win) else $error("strobe off frame");
endmodule // msc_top_properties

bind msc_top msc_top_properties chk_u (.clock_in(clock_in), .rst_in(rst_in),
  .cs_n_in(cs_n_in), .reply_data_oe_out(reply_data_oe_out), .irq_n_out(irq_n_out),
  .irq_n_oe_out(irq_n_oe_out),
  .hook_relay_pulldown_out(hook_relay_pulldown_out), .setup_out(setup_out),
  .hook_relay_pulldown_oe_out(hook_relay_pulldown_oe_out),
  .tx_data_strobe_out(tx_data_strobe_out), .rx_data_taken_out(rx_data_taken_out));

// *** dv/msc_host_model.sv ***
// Host side of the serial link: frames, clocks and shifts bytes.
// Assumes a free-running link clock; the serial clock idles low.
`timescale 1ns/10ps
module msc_host_model (
  // Link clock
  input wire logic lclk_in,
  // Reply from the device
  input wire logic reply_in,
  input wire logic reply_oe_in,
  // Serial outputs
  output logic sclk_out,
  output logic cs_n_out,
  output logic cmd_out
);
  initial begin
    sclk_out = 1'b0;
    // Late in time zero, so the link sees a rising select and clears its frame state
    cs_n_out <= 1'b1;
    cmd_out = 1'b0;
  end
  // One framed transfer of n bits, MSB first; reply taken while clock high
  task automatic frame(input logic [15:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    @(posedge lclk_in) cs_n_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge lclk_in) cmd_out <= b[15-i];
      @(posedge lclk_in) sclk_out <= 1'b1;
      @(posedge lclk_in) sclk_out <= 1'b0;
      // A released reply line shows the inverse, so an early release is caught
      r = {r[6:0], reply_oe_in ? reply_in : ~reply_in};
      cmd_out <= ~b[15-i]; // Hold ends: show the inverse level, not the bit
    end
    @(posedge lclk_in) cs_n_out <= 1'b1;
  endtask
endmodule // msc_host_model

// *** dv/modem_serial_control_port_tb.sv ***
// Testbench of the serial control port with a host model on the link.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`include "msc_params.svh"
module modem_serial_control_port_tb;
  logic clk = 0, lclk = 0, rst, ring = 0, txr = 0;
  logic sclk, cs_n, cmd, rd, rde, irq, irqe, rl, rle, stb, take;
  logic [7:0] rxd = 8'h00, setup, tones, fsk, txd, r, obs;
  logic [7:0] va[4];
  logic [7:0] expq[$];
  logic [31:0] adr = {`MSC_ADDR_SETUP, `MSC_ADDR_TXTONES, `MSC_ADDR_FSKMODE, `MSC_ADDR_TXDATA};
  int num_errors = 0, checks = 0, nstb = 0, ntake = 0;
  event seen;
  always #25 clk = ~clk;
  always #7.5 lclk = ~lclk;
  msc_top dut_u (.clock_in(clk), .rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n),
    .cmd_data_in(cmd), .reply_data_out(rd), .reply_data_oe_out(rde), .irq_n_out(irq),
    .irq_n_oe_out(irqe), .hook_relay_pulldown_out(rl), .hook_relay_pulldown_oe_out(rle),
    .ring_detect_in(ring), .tx_ready_in(txr), .tx_underflow_in(1'b0), .rx_ready_in(1'b0),
    .rx_overflow_in(1'b0), .rx_energy_in(1'b0), .rx_bad_parity_in(1'b0), .rx_data_in(rxd),
    .setup_out(setup), .tx_tones_out(tones), .fsk_mode_out(fsk), .tx_data_out(txd),
    .tx_data_strobe_out(stb), .rx_data_taken_out(take));
  msc_host_model host_u (.lclk_in(lclk), .reply_in(rd), .reply_oe_in(rde),
    .sclk_out(sclk), .cs_n_out(cs_n), .cmd_out(cmd));
  always @(posedge clk) if (stb === 1'b1) nstb++;
  always @(posedge clk) if (take === 1'b1) ntake++;
  // Oldest note against the value just observed
  always @(seen) begin
    checks++;
    if (expq.size() == 0 || obs !== expq[0]) begin
      num_errors++;
      $display("[ERR] %0t mismatch got %h", $time, obs);
    end
    if (expq.size() != 0) void'(expq.pop_front());
  end
  task automatic chk(input logic [7:0] o, input logic [7:0] e);
    expq.push_back(e);
    obs = o;
    -> seen;
    #1;
  endtask
  // Settle time also keeps frames 8 system cycles apart
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n);
    host_u.frame({a, d}, n, r);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic results();
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    // Set late in time zero so the link's event word sees a rising reset
    rst <= 1'b1;
    void'($urandom(45665));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(negedge clk);
    chk({5'h00, irqe, rde, rle}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      va[i] = 8'($urandom());
      xfer(adr[31-8*i -: 8], va[i], 16);
    end
    chk(setup, va[0]);
    chk(tones, va[1]);
    chk(fsk, va[2]);
    chk(txd, va[3]);
    chk({7'h00, rle}, {7'h00, va[0][5]});
    chk(8'(nstb), 8'h01);
    xfer(8'h55, ~va[0], 16); // Unmapped address
    xfer(`MSC_ADDR_FLAGS, ~va[0], 16); // Write to a read-only place
    chk(setup, va[0]);
    xfer(`MSC_ADDR_IRQMASK, 8'h01, 16);
    @(posedge clk) txr <= 1'b1;
    @(posedge clk) txr <= 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, irqe}, 8'h01);
    xfer(`MSC_ADDR_FLAGS, 8'h00, 16);
    chk(r, 8'h01);
    chk({7'h00, irqe}, 8'h00);
    @(posedge clk) ring <= 1'b1;
    repeat (8) @(negedge clk);
    chk({7'h00, irqe}, 8'h00);
    xfer(`MSC_ADDR_FLAGS, 8'h00, 16);
    chk(r, 8'h60);
    xfer(`MSC_ADDR_FLAGS, 8'h00, 16);
    chk(r, 8'h40);
    @(posedge clk) rxd <= 8'($urandom());
    xfer(`MSC_ADDR_RXDATA, 8'h00, 16);
    chk(r, rxd);
    chk(8'(ntake), 8'h01);
    xfer(`MSC_ADDR_RESET, 8'h00, 8);
    chk(setup | tones | fsk, 8'h00);
    chk({7'h00, rle}, 8'h00);
    chk(txd, 8'h00);
    results();
  end
endmodule // modem_serial_control_port_tb
